// file: rtl/tipt_pkg.sv
package tipt_pkg;

   // Controller states, one code each
   typedef enum logic [3:0]
   {
      ST_TLR    = 4'h0,
      ST_IDLE   = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SH_DR  = 4'h4,
      ST_EX1_DR = 4'h5,
      ST_PAU_DR = 4'h6,
      ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'ha,
      ST_SH_IR  = 4'hb,
      ST_EX1_IR = 4'hc,
      ST_PAU_IR = 4'hd,
      ST_EX2_IR = 4'he,
      ST_UPD_IR = 4'hf
   } tipt_state_t;

   // Link pins sampled on the rising test clock
   typedef struct packed
   {
      logic tms;
      logic tdi;
   } tipt_link_t;

   // Instruction register geometry
   localparam int IR_W_DEF = 3;
   localparam int IR_CAPTURE_W = 3;
   localparam logic [2:0] IR_CAPTURE_PAT = 3'h4;
   // Identification instruction code, value arbitrary
   localparam int IDCODE_INSTR_DEF = 1;

endpackage

// file: rtl/tipt_tap.sv
`timescale 1ns/10ps
// Behaviour
// - From Exit1-IR a high TMS goes to Update-IR and a low TMS to Pause-IR.
// - Pause-IR halts instruction shifting and stays put while TMS is low.
// - From Pause-IR a high TMS advances to Exit2-IR.
// - From Exit2-IR a high TMS goes to Update-IR, a low one back to Shift-IR.
// - In Exit1, Pause and Exit2 of the IR path instruction and data hold.
// - Update-IR copies the shift register to the instruction on falling TCK.
// - The latched instruction becomes the current one that selects data.
// - During Update-IR the selected data registers keep their value.
// - Shift-IR moves the register one stage toward TDO, high TMS to Exit1-IR.
// - Capture-IR loads the fixed pattern 100 into the shift register.
// - Five high TMS edges force Test-Logic-Reset and the id instruction.
module tipt_tap #(
   parameter int IR_W = tipt_pkg::IR_W_DEF,
   parameter int IDCODE_INSTR = tipt_pkg::IDCODE_INSTR_DEF
) (
   input wire logic tck_in, // Test clock from board controller
   input wire logic core_clk_in, // Core clock
   input wire logic rst_in, // Core reset, high
   input wire tipt_pkg::tipt_link_t link_in, // Mode select and serial in
   input wire logic dr_tdo_in, // Serial out of selected data reg
   output logic tdo_out, // Serial test out
   output logic tdo_oe_n_out, // Low while tdo_out is driven
   output logic [IR_W-1:0] ir_out, // Current instruction, test clock
   output tipt_pkg::tipt_state_t tap_state_out, // Controller state
   output logic dr_hold_out, // Selected data regs must hold
   output logic [IR_W-1:0] core_ir_out, // Current instruction, core clock
   output logic core_ir_new_out // Pulse on new core instruction
);

   localparam logic [IR_W-1:0] IDCODE_V = IR_W'(IDCODE_INSTR);

   // Refuse widths the capture pattern or id code cannot fit
   if (IR_W < tipt_pkg::IR_CAPTURE_W)
   begin : g_bad_w
      $error("tipt_tap instruction width below capture pattern");
   end
   if ((IDCODE_INSTR < 0) || (IDCODE_INSTR >= (1 << IR_W)))
   begin : g_bad_id
      $error("tipt_tap id instruction does not fit");
   end

   typedef struct packed
   {
      logic [2:0] rsync;
      logic rst;
      tipt_pkg::tipt_state_t state;
      logic [IR_W-1:0] sr;
      logic dr_hold;
   } tipt_pos_t;

   typedef struct packed
   {
      logic [IR_W-1:0] ir;
      logic tdo;
      logic tdo_oe_n;
   } tipt_neg_t;

   tipt_pos_t pos_ff;
   tipt_pos_t nxt_pos;
   tipt_neg_t neg_ff;
   tipt_neg_t nxt_neg;

   // Rising edge: reset crossing, state walk, shift register
   always_comb
   begin
      nxt_pos = pos_ff;
      nxt_pos.rsync = {pos_ff.rsync[1:0], rst_in};
      if (pos_ff.rsync[1] == pos_ff.rsync[2])
         nxt_pos.rst = pos_ff.rsync[2];
      if (pos_ff.rst)
      begin
         nxt_pos.state = tipt_pkg::ST_TLR;
         nxt_pos.sr = '0;
      end
      else
      begin
         // Next state from sampled TMS
         case (pos_ff.state)
            tipt_pkg::ST_TLR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_TLR
                                           : tipt_pkg::ST_IDLE;
            tipt_pkg::ST_IDLE:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_SEL_DR
                                           : tipt_pkg::ST_IDLE;
            tipt_pkg::ST_SEL_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_SEL_IR
                                           : tipt_pkg::ST_CAP_DR;
            tipt_pkg::ST_CAP_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX1_DR
                                           : tipt_pkg::ST_SH_DR;
            tipt_pkg::ST_SH_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX1_DR
                                           : tipt_pkg::ST_SH_DR;
            tipt_pkg::ST_EX1_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_UPD_DR
                                           : tipt_pkg::ST_PAU_DR;
            tipt_pkg::ST_PAU_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX2_DR
                                           : tipt_pkg::ST_PAU_DR;
            tipt_pkg::ST_EX2_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_UPD_DR
                                           : tipt_pkg::ST_SH_DR;
            tipt_pkg::ST_UPD_DR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_SEL_DR
                                           : tipt_pkg::ST_IDLE;
            tipt_pkg::ST_SEL_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_TLR
                                           : tipt_pkg::ST_CAP_IR;
            tipt_pkg::ST_CAP_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX1_IR
                                           : tipt_pkg::ST_SH_IR;
            tipt_pkg::ST_SH_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX1_IR
                                           : tipt_pkg::ST_SH_IR;
            tipt_pkg::ST_EX1_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_UPD_IR
                                           : tipt_pkg::ST_PAU_IR;
            tipt_pkg::ST_PAU_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_EX2_IR
                                           : tipt_pkg::ST_PAU_IR;
            tipt_pkg::ST_EX2_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_UPD_IR
                                           : tipt_pkg::ST_SH_IR;
            tipt_pkg::ST_UPD_IR:
               nxt_pos.state = link_in.tms ? tipt_pkg::ST_SEL_DR
                                           : tipt_pkg::ST_IDLE;
            default:
               nxt_pos.state = tipt_pkg::ST_TLR;
         endcase
         // Shift register moves only in capture and shift
         case (pos_ff.state)
            tipt_pkg::ST_CAP_IR:
               nxt_pos.sr = IR_W'(tipt_pkg::IR_CAPTURE_PAT);
            tipt_pkg::ST_SH_IR:
               nxt_pos.sr = {link_in.tdi, pos_ff.sr[IR_W-1:1]};
            default:
               nxt_pos.sr = pos_ff.sr;
         endcase
      end
      // Data regs free only in their own capture and shift
      nxt_pos.dr_hold = !((nxt_pos.state == tipt_pkg::ST_CAP_DR) ||
                          (nxt_pos.state == tipt_pkg::ST_SH_DR));
   end

   always_ff @(posedge tck_in)
      pos_ff <= nxt_pos;

   // Falling edge: instruction latch and serial out
   always_comb
   begin
      nxt_neg = neg_ff;
      case (pos_ff.state)
         tipt_pkg::ST_UPD_IR:
            nxt_neg.ir = pos_ff.sr;
         tipt_pkg::ST_TLR:
            nxt_neg.ir = IDCODE_V;
         default:
            nxt_neg.ir = neg_ff.ir;
      endcase
      if (pos_ff.state == tipt_pkg::ST_SH_IR)
      begin
         nxt_neg.tdo = pos_ff.sr[0];
         nxt_neg.tdo_oe_n = 1'b0;
      end
      else if (pos_ff.state == tipt_pkg::ST_SH_DR)
      begin
         nxt_neg.tdo = dr_tdo_in;
         nxt_neg.tdo_oe_n = 1'b0;
      end
      else
      begin
         nxt_neg.tdo = 1'b0;
         nxt_neg.tdo_oe_n = 1'b1;
      end
      if (pos_ff.rst)
      begin
         nxt_neg.ir = IDCODE_V;
         nxt_neg.tdo = 1'b0;
         nxt_neg.tdo_oe_n = 1'b1;
      end
   end

   always_ff @(negedge tck_in)
      neg_ff <= nxt_neg;

   // Current instruction passed to the core clock domain
   tipt_xfer #(
      .W(IR_W),
      .RST_VAL(IDCODE_V)
   ) u_xfer (
      .src_clk_in(tck_in),
      .src_rst_in(pos_ff.rst),
      .src_data_in(neg_ff.ir),
      .dst_clk_in(core_clk_in),
      .dst_rst_in(rst_in),
      .dst_data_out(core_ir_out),
      .dst_new_out(core_ir_new_out)
   );

   // Outputs straight from flops
   assign tdo_out = neg_ff.tdo;
   assign tdo_oe_n_out = neg_ff.tdo_oe_n;
   assign ir_out = neg_ff.ir;
   assign tap_state_out = pos_ff.state;
   assign dr_hold_out = pos_ff.dr_hold;

   // Checks on the test clock
   default clocking tipt_cb @(posedge tck_in);
   endclocking
   default disable iff (pos_ff.rst);

   exit1_next_a: assert property (
      pos_ff.state == tipt_pkg::ST_EX1_IR |=>
         pos_ff.state == ($past(link_in.tms) ? tipt_pkg::ST_UPD_IR
                                             : tipt_pkg::ST_PAU_IR))
      else $error("exit1 ir took wrong branch");

   pause_hold_a: assert property (
      (pos_ff.state == tipt_pkg::ST_PAU_IR) && !link_in.tms |=>
         (pos_ff.state == tipt_pkg::ST_PAU_IR) && $stable(pos_ff.sr))
      else $error("pause ir did not hold");

   pause_exit_a: assert property (
      (pos_ff.state == tipt_pkg::ST_PAU_IR) && link_in.tms |=>
         pos_ff.state == tipt_pkg::ST_EX2_IR)
      else $error("pause ir did not advance");

   exit2_next_a: assert property (
      pos_ff.state == tipt_pkg::ST_EX2_IR |=>
         pos_ff.state == ($past(link_in.tms) ? tipt_pkg::ST_UPD_IR
                                             : tipt_pkg::ST_SH_IR))
      else $error("exit2 ir took wrong branch");

   ir_steady_a: assert property (
      (pos_ff.state == tipt_pkg::ST_EX1_IR) ||
      (pos_ff.state == tipt_pkg::ST_PAU_IR) ||
      (pos_ff.state == tipt_pkg::ST_EX2_IR) |-> $stable(ir_out))
      else $error("instruction changed outside update");

   update_copy_a: assert property (
      pos_ff.state == tipt_pkg::ST_UPD_IR |-> ir_out == pos_ff.sr)
      else $error("update ir did not latch shift register");

   ir_keep_a: assert property (
      (pos_ff.state == tipt_pkg::ST_UPD_IR) ##1
      (pos_ff.state == tipt_pkg::ST_IDLE)[*3] |->
         ir_out == $past(ir_out, 3))
      else $error("current instruction not kept");

   dr_hold_a: assert property (
      (pos_ff.state == tipt_pkg::ST_EX1_IR) ||
      (pos_ff.state == tipt_pkg::ST_PAU_IR) ||
      (pos_ff.state == tipt_pkg::ST_EX2_IR) ||
      (pos_ff.state == tipt_pkg::ST_UPD_IR) |-> dr_hold_out)
      else $error("data registers not held in ir path");

   shift_move_a: assert property (
      pos_ff.state == tipt_pkg::ST_SH_IR |=>
         pos_ff.sr == {$past(link_in.tdi), $past(pos_ff.sr[IR_W-1:1])})
      else $error("shift ir did not move one stage");

   shift_tdo_a: assert property (
      pos_ff.state == tipt_pkg::ST_SH_IR |->
         !tdo_oe_n_out && (tdo_out == pos_ff.sr[0]))
      else $error("tdo not driven from shift register");

   capture_load_a: assert property (
      pos_ff.state == tipt_pkg::ST_CAP_IR |=>
         pos_ff.sr == IR_W'(tipt_pkg::IR_CAPTURE_PAT))
      else $error("capture ir loaded wrong pattern");

   tlr_five_a: assert property (
      link_in.tms[*5] |=> pos_ff.state == tipt_pkg::ST_TLR)
      else $error("five high tms did not reset");

   tlr_idcode_a: assert property (
      pos_ff.state == tipt_pkg::ST_TLR |=> ir_out == IDCODE_V)
      else $error("reset state did not load id instruction");

   pause_quiet_a: assert property (
      pos_ff.state == tipt_pkg::ST_PAU_IR |-> tdo_oe_n_out && !tdo_out)
      else $error("pause ir still drives tdo");

   dr_free_a: assert property (
      pos_ff.state == tipt_pkg::ST_SH_DR |-> !dr_hold_out)
      else $error("data registers held during data shift");

   // Main scenarios
   pause_loop_c: cover property (
      (pos_ff.state == tipt_pkg::ST_PAU_IR)[*2] ##1
      (pos_ff.state == tipt_pkg::ST_EX2_IR));
   resume_shift_c: cover property (
      (pos_ff.state == tipt_pkg::ST_EX2_IR) ##1
      (pos_ff.state == tipt_pkg::ST_SH_IR));
   update_via_exit2_c: cover property (
      (pos_ff.state == tipt_pkg::ST_EX2_IR) ##1
      (pos_ff.state == tipt_pkg::ST_UPD_IR));
   tms_reset_c: cover property (
      (pos_ff.state == tipt_pkg::ST_SH_IR) ##[1:8]
      (pos_ff.state == tipt_pkg::ST_TLR));

endmodule // tipt_tap

// file: rtl/tipt_xfer.sv
`timescale 1ns/10ps
// Word crossing by toggle handshake between test clock and core clock
module tipt_xfer #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic src_clk_in, // Source side clock
   input wire logic src_rst_in, // Source side reset, high
   input wire logic [W-1:0] src_data_in, // Word to forward
   input wire logic dst_clk_in, // Destination clock
   input wire logic dst_rst_in, // Destination reset, high
   output logic [W-1:0] dst_data_out, // Forwarded word
   output logic dst_new_out // One cycle on each new word
);

   // Refuse a zero width
   if (W < 1)
   begin : g_bad_w
      $error("tipt_xfer width must be positive");
   end

   typedef struct packed
   {
      logic [W-1:0] sent;
      logic req;
      logic [2:0] ack_sync;
      logic ack_seen;
   } tipt_src_t;

   typedef struct packed
   {
      logic [W-1:0] data;
      logic [2:0] req_sync;
      logic ack;
      logic new_w;
   } tipt_dst_t;

   tipt_src_t src_ff;
   tipt_src_t nxt_src;
   tipt_dst_t dst_ff;
   tipt_dst_t nxt_dst;

   // Source: hold word stable until acknowledged, then send next
   always_comb
   begin
      nxt_src = src_ff;
      nxt_src.ack_sync = {src_ff.ack_sync[1:0], dst_ff.ack};
      if (src_ff.ack_sync[1] == src_ff.ack_sync[2])
         nxt_src.ack_seen = src_ff.ack_sync[2];
      if ((src_ff.req == src_ff.ack_seen) && (src_data_in != src_ff.sent))
      begin
         nxt_src.sent = src_data_in;
         nxt_src.req = ~src_ff.req;
      end
      if (src_rst_in)
      begin
         nxt_src.sent = RST_VAL;
         nxt_src.req = 1'b0;
         nxt_src.ack_seen = 1'b0;
      end
   end

   always_ff @(posedge src_clk_in)
      src_ff <= nxt_src;

   // Destination: take word once request toggle has settled
   always_comb
   begin
      nxt_dst = dst_ff;
      nxt_dst.req_sync = {dst_ff.req_sync[1:0], src_ff.req};
      nxt_dst.new_w = 1'b0;
      if ((dst_ff.req_sync[1] == dst_ff.req_sync[2]) &&
          (dst_ff.req_sync[2] != dst_ff.ack))
      begin
         nxt_dst.data = src_ff.sent;
         nxt_dst.ack = dst_ff.req_sync[2];
         nxt_dst.new_w = 1'b1;
      end
      if (dst_rst_in)
      begin
         nxt_dst.data = RST_VAL;
         nxt_dst.ack = 1'b0;
         nxt_dst.new_w = 1'b0;
      end
   end

   always_ff @(posedge dst_clk_in)
      dst_ff <= nxt_dst;

   // Outputs from destination flops
   assign dst_data_out = dst_ff.data;
   assign dst_new_out = dst_ff.new_w;

endmodule // tipt_xfer

// file: verification/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
      end \
   end

// Self-checking bench for the instruction path tail
module testbench;
   localparam logic [2:0] IDC = 3'(tipt_pkg::IDCODE_INSTR_DEF);
   logic core_clk_in;
   logic rst_in;
   logic tck;
   tipt_pkg::tipt_link_t link;
   logic tdo;
   logic oe_n;
   logic [2:0] ir;
   logic [2:0] core_ir;
   tipt_pkg::tipt_state_t st;
   logic hold;
   logic core_new;
   logic [2:0] last_word;
   int mismatches = 0;
   int total_checks = 0;

   tipt_ctrl_model model (
      .tck_out(tck),
      .link_out(link)
   );

   tipt_tap dut (
      .tck_in(tck),
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .link_in(link),
      .dr_tdo_in(1'b0),
      .tdo_out(tdo),
      .tdo_oe_n_out(oe_n),
      .ir_out(ir),
      .tap_state_out(st),
      .dr_hold_out(hold),
      .core_ir_out(core_ir),
      .core_ir_new_out(core_new)
   );

   // Core clock, 40 ns period
   initial
   begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   // Record each word announced on the core side
   always
   begin
      @(posedge core_clk_in);
      #1;
      if (core_new === 1'b1)
         last_word = core_ir;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Keep the test clock going until the core side shows a word
   task automatic wait_core(input logic [2:0] exp, input logic tms);
      int i;
      for (i = 0; i < 40 && last_word !== exp; i++)
         model.step(tms, 1'b0);
      `CHK("core_word", exp, last_word)
      `CHK("core_ir", exp, core_ir)
   endtask

   // From idle through capture into instruction shift
   task automatic enter_shift();
      model.step(1'b1, 1'b0);
      model.step(1'b1, 1'b0);
      model.step(1'b0, 1'b0);
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_SH_IR, st)
      `CHK("oe_n", 1'b0, oe_n)
      `CHK("tdo_cap0", 1'b0, tdo)
   endtask

   // Reset values after both resets
   task automatic check_reset();
      `CHK("state", tipt_pkg::ST_TLR, st)
      `CHK("ir", IDC, ir)
      `CHK("oe_n", 1'b1, oe_n)
      `CHK("hold", 1'b1, hold)
      `CHK("core_ir", IDC, core_ir)
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_IDLE, st)
   endtask

   // Data scan frees the data regs, so hold is not stuck high
   task automatic check_dr_free();
      model.step(1'b1, 1'b0);
      model.step(1'b0, 1'b0);
      `CHK("hold_cap", 1'b0, hold)
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_SH_DR, st)
      `CHK("hold_shift", 1'b0, hold)
      model.step(1'b1, 1'b0);
      `CHK("hold_exit", 1'b1, hold)
      model.step(1'b1, 1'b0);
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_IDLE, st)
      `CHK("ir", IDC, ir)
   endtask

   // Scan 3'h6 with a pause and a return to shift in mid-word
   task automatic scan_paused();
      enter_shift();
      model.step(1'b0, 1'b0);
      `CHK("tdo_cap1", 1'b0, tdo)
      model.step(1'b1, 1'b1);
      `CHK("state", tipt_pkg::ST_EX1_IR, st)
      `CHK("ir", IDC, ir)
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_PAU_IR, st)
      repeat (3) model.step(1'b0, 1'b1);
      `CHK("state", tipt_pkg::ST_PAU_IR, st)
      `CHK("ir", IDC, ir)
      `CHK("hold", 1'b1, hold)
      `CHK("oe_n", 1'b1, oe_n)
      model.step(1'b1, 1'b0);
      `CHK("state", tipt_pkg::ST_EX2_IR, st)
      `CHK("ir", IDC, ir)
      model.step(1'b0, 1'b0);
      `CHK("state", tipt_pkg::ST_SH_IR, st)
      `CHK("tdo_cap2", 1'b1, tdo)
      model.step(1'b1, 1'b1);
      model.step(1'b1, 1'b0);
      `CHK("state", tipt_pkg::ST_UPD_IR, st)
      `CHK("hold", 1'b1, hold)
      `CHK("ir", 3'h6, ir)
      model.step(1'b0, 1'b0);
      wait_core(3'h6, 1'b0);
   endtask

   // Scan 3'h3 and update from the second exit state
   task automatic scan_exit2();
      enter_shift();
      model.step(1'b0, 1'b1);
      model.step(1'b0, 1'b1);
      model.step(1'b1, 1'b0);
      `CHK("ir", 3'h6, ir)
      model.step(1'b0, 1'b1);
      model.step(1'b1, 1'b1);
      `CHK("ir", 3'h6, ir)
      model.step(1'b1, 1'b0);
      `CHK("state", tipt_pkg::ST_UPD_IR, st)
      `CHK("ir", 3'h3, ir)
      `CHK("hold", 1'b1, hold)
      model.step(1'b0, 1'b0);
      wait_core(3'h3, 1'b0);
   endtask

   // Five high mode edges from pause reach reset state
   task automatic check_tlr();
      enter_shift();
      model.step(1'b1, 1'b0);
      model.step(1'b0, 1'b0);
      model.force_reset(5);
      `CHK("state", tipt_pkg::ST_TLR, st)
      `CHK("ir", IDC, ir)
      wait_core(IDC, 1'b1);
   endtask

   // Main sequence
   initial
   begin
      rst_in = 1'b1;
      fork
         begin
            repeat (5) @(posedge core_clk_in);
            #2 rst_in = 1'b0;
         end
         model.force_reset(8);
      join
      model.force_reset(7);
      check_reset();
      check_dr_free();
      scan_paused();
      scan_exit2();
      check_tlr();
      finish_test();
   end

   // Watchdog well beyond the expected run time
   initial
   begin
      #50000;
      mismatches++;
      finish_test();
   end
endmodule // testbench

// file: verification/tipt_ctrl_model.sv
`timescale 1ns/10ps
// Board test controller: drives the test clock and the link pins
module tipt_ctrl_model (
   output logic tck_out, // Test clock, still between steps
   output tipt_pkg::tipt_link_t link_out // Mode select and serial data
);
   // Quiet link before the first step
   initial
   begin
      tck_out = 1'b0;
      link_out = '0;
   end

   // One test clock period, pins held across the rising edge
   task automatic step(input logic tms, input logic tdi);
      link_out.tms = tms;
      link_out.tdi = tdi;
      #14 tck_out = 1'b1;
      #15 tck_out = 1'b0;
      // Serial data hold has run out, so show a changed value
      link_out.tdi = ~tdi;
      #1;
   endtask

   // Mode select held high for n rising edges forces reset state
   task automatic force_reset(input int n);
      repeat (n) step(1'b1, 1'b0);
   endtask
endmodule // tipt_ctrl_model
